// ==== wdt_pkg.sv ====
// package: register map, field layout, reset values for the watchdog period block
package wdt_pkg;
    localparam logic [11:0] PERIOD_SEL_INDEX = 12'h0A7;
    localparam logic [11:0] PERIOD_SEL_ADDR = PERIOD_SEL_INDEX << 2;
    localparam logic [11:0] IRQ_STATUS_ADDR = 12'h100;
    localparam logic [11:0] IRQ_MASK_ADDR = 12'h104;
    localparam logic [11:0] MODE_CTRL_ADDR = 12'h108;
    localparam logic [11:0] COUNT_ADDR = 12'h10C;
    localparam int SEL_LSB = 0;
    localparam int SEL_WIDTH = 3;
    localparam logic [2:0] SEL_RESET = 3'h0;
    localparam int BASE_EXP = 14;
    localparam int MODE_IDLE_BIT = 0;
    localparam int MODE_PDOWN_BIT = 1;
    localparam int MODE_RESTART_BIT = 2;
    localparam int ST_OVF_BIT = 0;
    localparam int ST_WAKE_BIT = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    typedef enum {WDT_RUN, WDT_PDOWN, WDT_WAKEHOLD} wdt_state_e;
endpackage

// ==== wdt_cnt_if.sv ====
// interface: controls and status between the top and the counter
`timescale 1ns/100ps
interface wdt_cnt_if #(parameter int CW = 21);
    logic run;
    logic restart;
    logic [2:0] sel;
    logic overflow;
    logic [CW-1:0] count;
    modport ctrl (output run, output restart, output sel, input overflow, input count);
    modport cnt (input run, input restart, input sel, output overflow, output count);
endinterface

// ==== wdt_counter.sv ====
// module: machine-cycle watchdog counter with selectable terminal count
`timescale 1ns/100ps
module wdt_counter #(
    parameter int CW = 21
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // control and status
    wdt_cnt_if.cnt bus
);
    logic [CW-1:0] countReg;
    logic [CW-1:0] countNext;
    logic ovfReg;
    logic ovfNext;
    logic [CW-1:0] termVal;

    if (CW != wdt_pkg::BASE_EXP + 7) begin : g_cw_check
        $error("counter width must be base exponent plus seven");
    end

    function automatic logic [CW-1:0] term_of(input logic [2:0] s);
        term_of = CW'((64'h1 << (wdt_pkg::BASE_EXP + int'(s))) - 64'h1);
    endfunction

    assign termVal = term_of(bus.sel);

    always_comb begin
        countNext = countReg;
        ovfNext = 1'b0;
        if (bus.restart) begin
            countNext = '0;
        end else if (bus.run) begin
            if (countReg + CW'(1) >= termVal) begin
                countNext = '0;
                ovfNext = 1'b1;
            end else begin
                countNext = countReg + CW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            countReg <= '0;
            ovfReg <= 1'b0;
        end else begin
            countReg <= countNext;
            ovfReg <= ovfNext;
        end
    end

    assign bus.count = countReg;
    assign bus.overflow = ovfReg;
endmodule

// ==== wdt_period_top.sv ====
// module: watchdog period select, low-power behaviour and APB registers
//
// Overview of operation
// - period select register at 0A7h, low three bits give exponent 14 to 21
// - select field resets to zero; upper bits not stored, read as zero
// - counter never advances or overflows while in power-down; it keeps its value unless a restart is written
// - power-down exits only by reset or enabled level external interrupt
// - interrupt service request raised only after interrupt line returns high
// - after interrupt wake, counter stays stopped while line is low
// - counter keeps advancing and may overflow during idle
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
module wdt_period_top #(
    parameter int CW = 21
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // external wake interrupt, active low level, and its enable
    input wire logic extIntN,
    input wire logic extIntEnable,
    // system side
    output logic overflowReset,
    output logic wakeService,
    output logic irq
);
    wdt_cnt_if #(.CW(CW)) cbus();

    logic [2:0] selReg, selNext;
    logic [1:0] stReg, stNext;
    logic [1:0] maskReg, maskNext;
    logic idleReg, idleNext;
    logic restartReg, restartNext;
    logic [31:0] rdReg, rdNext;
    logic readyReg, readyNext;
    logic errReg, errNext;
    logic ovfOutReg, ovfOutNext;
    logic wakeReg, wakeNext;
    logic irqReg, irqNext;
    logic pdEnReg, pdEnNext;
    wdt_pkg::wdt_state_e stateReg, stateNext;
    logic wrAcc, rdAcc;
    logic [1:0] stSet;

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == wdt_pkg::PERIOD_SEL_ADDR) || (a == wdt_pkg::IRQ_STATUS_ADDR)
            || (a == wdt_pkg::IRQ_MASK_ADDR) || (a == wdt_pkg::MODE_CTRL_ADDR)
            || (a == wdt_pkg::COUNT_ADDR);
    endfunction

    if (CW != wdt_pkg::BASE_EXP + 7) begin : g_cw_check
        $error("counter width must be base exponent plus seven");
    end

    // writes land at the edge where the master sees pready high
    assign wrAcc = psel && penable && pwrite && readyReg;
    assign rdAcc = psel && penable && !pwrite && !readyReg;

    wdt_counter #(.CW(CW)) u_counter (
        .clk(clk),
        .srst(srst),
        .bus(cbus)
    );

    assign cbus.sel = selReg;
    assign cbus.restart = restartReg;
    assign cbus.run = (stateReg == wdt_pkg::WDT_RUN);

    // power state machine
    always_comb begin
        stateNext = stateReg;
        wakeNext = 1'b0;
        case (stateReg)
            wdt_pkg::WDT_RUN: begin
                if (wrAcc && paddr == wdt_pkg::MODE_CTRL_ADDR
                        && pwdata[wdt_pkg::MODE_PDOWN_BIT]) begin
                    stateNext = wdt_pkg::WDT_PDOWN;
                end
            end
            wdt_pkg::WDT_PDOWN: begin
                if (pdEnReg && !extIntN) begin
                    stateNext = wdt_pkg::WDT_WAKEHOLD;
                end
            end
            wdt_pkg::WDT_WAKEHOLD: begin
                if (extIntN) begin
                    stateNext = wdt_pkg::WDT_RUN;
                    wakeNext = 1'b1;
                end
            end
            default: begin
                stateNext = wdt_pkg::WDT_RUN;
            end
        endcase
    end

    // power state registers
    always_ff @(posedge clk) begin
        if (srst) begin
            wakeReg <= 1'b0;
            stateReg <= wdt_pkg::WDT_RUN;
        end else begin
            wakeReg <= wakeNext;
            stateReg <= stateNext;
        end
    end

    // apb response: one wait state, error on unmapped address
    always_comb begin
        readyNext = 1'b0;
        errNext = 1'b0;
        if (psel && penable && !readyReg) begin
            readyNext = 1'b1;
            errNext = !is_mapped(paddr);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            readyReg <= 1'b0;
            errReg <= 1'b0;
        end else begin
            readyReg <= readyNext;
            errReg <= errNext;
        end
    end

    // read data captured in the first access cycle
    always_comb begin
        rdNext = rdReg;
        if (rdAcc) begin
            case (paddr)
                wdt_pkg::PERIOD_SEL_ADDR: rdNext = {29'h0, selReg};
                wdt_pkg::IRQ_STATUS_ADDR: rdNext = {30'h0, stReg};
                wdt_pkg::IRQ_MASK_ADDR: rdNext = {30'h0, maskReg};
                wdt_pkg::MODE_CTRL_ADDR: begin
                    rdNext = {30'h0, stateReg != wdt_pkg::WDT_RUN, idleReg};
                end
                wdt_pkg::COUNT_ADDR: rdNext = 32'(cbus.count);
                default: rdNext = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdReg <= 32'h0;
        end else begin
            rdReg <= rdNext;
        end
    end

    // control registers: select, mask, idle, restart, wake enable
    always_comb begin
        selNext = selReg;
        maskNext = maskReg;
        idleNext = idleReg;
        restartNext = 1'b0;
        pdEnNext = pdEnReg;
        if (stateReg == wdt_pkg::WDT_RUN) begin
            pdEnNext = extIntEnable;
        end
        if (wakeReg) begin
            idleNext = 1'b0;
        end
        if (wrAcc) begin
            case (paddr)
                wdt_pkg::PERIOD_SEL_ADDR: begin
                    selNext = pwdata[wdt_pkg::SEL_LSB +: wdt_pkg::SEL_WIDTH];
                end
                wdt_pkg::IRQ_MASK_ADDR: begin
                    maskNext = pwdata[1:0];
                end
                wdt_pkg::MODE_CTRL_ADDR: begin
                    idleNext = pwdata[wdt_pkg::MODE_IDLE_BIT];
                    restartNext = pwdata[wdt_pkg::MODE_RESTART_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            selReg <= wdt_pkg::SEL_RESET;
            maskReg <= wdt_pkg::IRQ_RESET;
            idleReg <= 1'b0;
            restartReg <= 1'b0;
            pdEnReg <= 1'b0;
        end else begin
            selReg <= selNext;
            maskReg <= maskNext;
            idleReg <= idleNext;
            restartReg <= restartNext;
            pdEnReg <= pdEnNext;
        end
    end

    // sticky status: write one clears, a new event wins
    always_comb begin
        stSet = {wakeReg, cbus.overflow};
        stNext = stReg;
        if (wrAcc && paddr == wdt_pkg::IRQ_STATUS_ADDR) begin
            stNext = stReg & ~pwdata[1:0];
        end
        stNext = stNext | stSet;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            stReg <= wdt_pkg::IRQ_RESET;
        end else begin
            stReg <= stNext;
        end
    end

    // registered system outputs
    always_comb begin
        ovfOutNext = cbus.overflow;
        irqNext = |(stNext & maskNext);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ovfOutReg <= 1'b0;
            irqReg <= 1'b0;
        end else begin
            ovfOutReg <= ovfOutNext;
            irqReg <= irqNext;
        end
    end

    assign prdata = rdReg;
    assign pready = readyReg;
    assign pslverr = errReg;
    assign overflowReset = ovfOutReg;
    assign wakeService = wakeReg;
    assign irq = irqReg;
endmodule

// ==== wdt_period_monitor.sv ====
// checker: port assertions of the watchdog period block
`timescale 1ns/100ps
module wdt_period_chk (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // wake and system
    input wire logic extIntN,
    input wire logic overflowReset,
    input wire logic wakeService,
    input wire logic irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    AST_RDY_WAIT: assert property (psel && penable && !pready |=> pready)
        else $error("ready late");
    AST_RDY_ONE: assert property (pready |=> !pready) else $error("ready long");
    AST_ERR_RDY: assert property (pslverr |-> pready) else $error("error alone");
    AST_OVF_ONE: assert property (overflowReset |=> !overflowReset [*8])
        else $error("overflow repeats");
    AST_WAKE_HI: assert property (wakeService |-> $past(extIntN))
        else $error("service while low");
    AST_WAKE_HELD: assert property (!extIntN && !$past(extIntN) |-> !wakeService)
        else $error("service during hold");
    AST_WAKE_ONE: assert property (wakeService |=> !wakeService)
        else $error("service long");
    AST_RST_OUT: assert property ($past(srst) |-> !overflowReset && !wakeService && !irq)
        else $error("output after reset");
    cover property (pslverr);
    cover property (overflowReset);
    cover property (wakeService);
endmodule
bind wdt_period_top wdt_period_chk chk (.clk, .srst, .psel, .penable, .pready, .pslverr,
    .extIntN, .overflowReset, .wakeService, .irq);

// ==== tb.sv ====
// testbench: register, overflow and wake sequences for the watchdog period block
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin mismatches++; \
    $display("BAD %0t %h %h", $time, (a), (e)); end end
module tb;
    localparam logic [11:0] SEL = wdt_pkg::PERIOD_SEL_ADDR;
    localparam logic [11:0] MODE = wdt_pkg::MODE_CTRL_ADDR;
    localparam logic [11:0] CNT = wdt_pkg::COUNT_ADDR;
    localparam logic [11:0] MSK = wdt_pkg::IRQ_MASK_ADDR;
    logic clk = 1'h0;
    logic srst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic extIntN = 1'h1;
    logic extIntEnable = 1'h0;
    logic [31:0] prdata, rd, c0;
    logic pready, pslverr, overflowReset, wakeService, irq, er;
    int mismatches = 0;
    int n_compared = 0;
    int n;
    wdt_period_top dut (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .extIntN, .extIntEnable, .overflowReset, .wakeService, .irq);
    initial forever #25 clk = ~clk;
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rdr(input logic [11:0] a);
        apb(1'h0, a, 32'h0);
    endtask
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #3000000;
        mismatches++;
        results();
    end
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'h0;
        rdr(SEL);
        `CHK(rd, 32'h0)
        wr(SEL, 32'hFFFF_FFFD);
        rdr(SEL);
        `CHK(rd, 32'h5)
        rdr(12'h200);
        `CHK({er, rd}, 33'h1_0000_0000)
        $display("test registers done");
        wr(SEL, 32'h0);
        wr(MSK, 32'h1);
        wr(MODE, 32'h5);
        for (n = 0; n < 17000 && overflowReset !== 1'h1; n++) @(posedge clk);
        `CHK(n > 16370 && n < 16390, 1'h1)
        repeat (3) @(posedge clk);
        `CHK(irq, 1'h1)
        wr(MSK, 32'h0);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'h0)
        wr(wdt_pkg::IRQ_STATUS_ADDR, 32'h1);
        wr(MSK, 32'h1);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'h0)
        wr(MODE, 32'h5);
        rdr(CNT);
        `CHK(rd < 32'h40, 1'h1)
        $display("test overflow done");
        extIntEnable <= 1'h1;
        wr(MODE, 32'h4);
        wr(MODE, 32'h2);
        rdr(CNT);
        c0 = rd;
        repeat (200) @(posedge clk);
        rdr(CNT);
        `CHK(rd, c0)
        extIntN <= 1'h0;
        repeat (50) @(posedge clk);
        rdr(CNT);
        `CHK(rd, c0)
        rdr(MODE);
        `CHK(rd[1], 1'h1)
        extIntN <= 1'h1;
        for (n = 0; n < 9 && wakeService !== 1'h1; n++) @(posedge clk);
        `CHK(n < 4, 1'h1)
        repeat (20) @(posedge clk);
        rdr(CNT);
        `CHK(rd > c0, 1'h1)
        rdr(wdt_pkg::IRQ_STATUS_ADDR);
        `CHK(rd[1], 1'h1)
        wr(MODE, 32'h4);
        rdr(CNT);
        `CHK(rd < 32'h40, 1'h1)
        $display("test wake done");
        extIntEnable <= 1'h0;
        wr(MODE, 32'h2);
        extIntN <= 1'h0;
        repeat (20) @(posedge clk);
        rdr(MODE);
        `CHK(rd[1], 1'h1)
        srst <= 1'h1;
        extIntN <= 1'h1;
        repeat (2) @(posedge clk);
        srst <= 1'h0;
        rdr(MODE);
        `CHK(rd[1:0], 2'h0)
        wr(MODE, 32'h4);
        rdr(CNT);
        `CHK(rd < 32'h40, 1'h1)
        $display("test exit done");
        results();
    end
endmodule
